/* File: rtl/flash_lock_pkg.sv */
// Shared constants and carrier types for the flash readout lock.
// Assumes a byte-wide program flash mapped from a fixed base address.
package flash_lock_pkg;

   // ***************************************************************
   // Widths and map
   // ***************************************************************
   localparam int ADDR_W = 20;
   localparam int PWD_W  = 32;
   localparam int LEN_W  = 17;
   localparam int DATA_W = 8;

   localparam logic [ADDR_W-1:0] FLASH_BASE  = 20'h90000;
   localparam logic [LEN_W-1:0]  FLASH_BYTES = 17'h10000; // 64 KB array
   localparam logic [LEN_W-1:0]  LEN_NONE    = 17'h00000;
   localparam logic [PWD_W-1:0]  PWD_DEFAULT = 32'hFFFFFFFF; // Unset value
   localparam logic [DATA_W-1:0] ERASED      = 8'hFF;
   localparam logic [DATA_W-1:0] DATA_NONE   = 8'h00;

   // ***************************************************************
   // Commands from the programming tool
   // ***************************************************************
   typedef enum logic [2:0] {
      CMD_CONNECT,
      CMD_PASSWORD,
      CMD_READ,
      CMD_PROTECT,
      CMD_FULL_ERASE
   } cmd_op_t;

   typedef struct packed {
      cmd_op_t             op;
      logic [ADDR_W-1:0]   addr;
      logic [PWD_W-1:0]    data;
      logic [LEN_W-1:0]    size;
      logic                noPw;
   } cmd_req_t;

   // Persistent protection image
   typedef struct packed {
      logic [PWD_W-1:0]    password;
      logic [LEN_W-1:0]    appSize;
      logic                noPw;
   } prot_t;

   localparam prot_t PROT_CLEAR = '{password: PWD_DEFAULT,
                                    appSize:  LEN_NONE,
                                    noPw:     1'b0};

endpackage

/* File: rtl/erase_sweeper.sv */
// Byte-by-byte erase walker: writes the erased value over a range.
// Assumes the flash accepts one byte write per clock.
`timescale 1ns/1ps
module erase_sweeper (
   // Clock and reset
   input  wire logic                                clk_sys,
   input  wire logic                                resetn,
   // Control from the lock controller
   input  wire logic                                start,
   input  wire logic [flash_lock_pkg::ADDR_W-1:0]   base,
   input  wire logic [flash_lock_pkg::LEN_W-1:0]    len,
   output      logic                                done,
   // Flash write port
   output      logic                                wrEn,
   output      logic [flash_lock_pkg::ADDR_W-1:0]   wrAddr,
   output      logic [flash_lock_pkg::DATA_W-1:0]   wrData
);

   logic [flash_lock_pkg::LEN_W-1:0] left;

   // ***************************************************************
   // Sweep engine
   // ***************************************************************
   // One byte per cycle; a zero length finishes at once
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         left   <= flash_lock_pkg::LEN_NONE;
         wrEn   <= 1'b0;
         wrAddr <= flash_lock_pkg::FLASH_BASE;
         wrData <= flash_lock_pkg::ERASED;
         done   <= 1'b0;
      end else begin
         done   <= 1'b0;
         wrData <= flash_lock_pkg::ERASED;
         if (start) begin
            wrAddr <= base;
            left   <= len;
            wrEn   <= (len != flash_lock_pkg::LEN_NONE);
            done   <= (len == flash_lock_pkg::LEN_NONE);
         end else if (wrEn) begin
            if (left == 17'h00001) begin
               wrEn <= 1'b0;
               done <= 1'b1;
            end else begin
               wrAddr <= wrAddr + 20'h00001;
            end
            left <= left - 17'h00001;
         end
      end
   end

endmodule // erase_sweeper

/* File: rtl/flash_readout_lock.sv */
// Readout lock controller between a programming tool and program flash.
// Assumes flash read data arrives one cycle after the read enable and the
// protection image is kept by an outside non-volatile store.
//
// Behaviour
// - An all-ones password means unset; any other value enables it.
// - Each new connection must present the password before access.
// - A correct password erases the application bytes to 0xFF.
// - That erase covers only the application size set with it.
// - After that erase the password returns to all-ones.
// - A full erase clears the whole 64 KB without a password.
// - Passwordless protection refuses every flash readback.
// - Passwordless protection unlocks only by a full erase to 0xFF.
`timescale 1ns/1ps
module flash_readout_lock (
   // Clock and reset
   input  wire logic                                  clk_sys,
   input  wire logic                                  resetn,
   // Command side, from the programming tool
   input  wire logic                                  cmdValid,
   input  wire flash_lock_pkg::cmd_req_t              cmdReq,
   output      logic                                  cmdReady,
   output      logic                                  rspValid,
   output      logic                                  rspOk,
   output      logic [flash_lock_pkg::DATA_W-1:0]     rspData,
   // Flash read port
   output      logic                                  flashRdEn,
   output      logic [flash_lock_pkg::ADDR_W-1:0]     flashRdAddr,
   input  wire logic [flash_lock_pkg::DATA_W-1:0]     flashRdData,
   // Flash erase write port
   output      logic                                  flashWrEn,
   output      logic [flash_lock_pkg::ADDR_W-1:0]     flashWrAddr,
   output      logic [flash_lock_pkg::DATA_W-1:0]     flashWrData,
   // Persistent protection image and session grant
   input  wire flash_lock_pkg::prot_t                 protRestore,
   output      flash_lock_pkg::prot_t                 prot,
   output      logic                                  granted
);

   typedef enum logic [2:0] {
      S_LOAD, S_IDLE, S_RD_WAIT, S_RD_DATA, S_ERASE_APP, S_ERASE_ALL
   } state_t;

   state_t                               state;
   logic                                 take;
   logic                                 pwSet;
   logic                                 pwMatch;
   logic                                 sweepStart;
   logic [flash_lock_pkg::LEN_W-1:0]     sweepLen;
   logic                                 sweepDone;

   // ***************************************************************
   // Decode
   // ***************************************************************
   assign take    = cmdValid && cmdReady && (state == S_IDLE);
   assign pwSet   = (prot.password != flash_lock_pkg::PWD_DEFAULT);
   assign pwMatch = (cmdReq.data == prot.password);

   // ***************************************************************
   // Sequencer
   // ***************************************************************
   // Busy states drop ready so nothing slips in during an erase
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         state      <= S_LOAD;
         cmdReady   <= 1'b0;
         rspValid   <= 1'b0;
         rspOk      <= 1'b0;
         rspData    <= flash_lock_pkg::DATA_NONE;
         flashRdEn  <= 1'b0;
         flashRdAddr <= flash_lock_pkg::FLASH_BASE;
         sweepStart <= 1'b0;
         sweepLen   <= flash_lock_pkg::LEN_NONE;
      end else begin
         rspValid   <= 1'b0;
         sweepStart <= 1'b0;
         flashRdEn  <= 1'b0;
         unique case (state)
            S_LOAD: begin
               state    <= S_IDLE;
               cmdReady <= 1'b1;
            end
            S_IDLE: begin
               cmdReady <= !take;
               if (take) begin
                  unique case (cmdReq.op)
                     flash_lock_pkg::CMD_READ: begin
                        // Locked or passwordless: no flash access at all
                        if (granted && !prot.noPw) begin
                           flashRdEn   <= 1'b1;
                           flashRdAddr <= cmdReq.addr;
                           state       <= S_RD_WAIT;
                        end else begin
                           rspValid <= 1'b1;
                           rspOk    <= 1'b0;
                           rspData  <= flash_lock_pkg::DATA_NONE;
                        end
                     end
                     flash_lock_pkg::CMD_PASSWORD: begin
                        if (pwSet && !prot.noPw && pwMatch) begin
                           sweepStart <= 1'b1;
                           sweepLen   <= prot.appSize;
                           state      <= S_ERASE_APP;
                        end else begin
                           // Wrong or pointless password: no erase; answered ok only when no lock is set
                           rspValid <= 1'b1;
                           rspOk    <= !pwSet && !prot.noPw;
                        end
                     end
                     flash_lock_pkg::CMD_FULL_ERASE: begin
                        sweepStart <= 1'b1;
                        sweepLen   <= flash_lock_pkg::FLASH_BYTES;
                        state      <= S_ERASE_ALL;
                     end
                     flash_lock_pkg::CMD_CONNECT,
                     flash_lock_pkg::CMD_PROTECT: begin
                        rspValid <= 1'b1;
                        rspOk    <= (cmdReq.op == flash_lock_pkg::CMD_CONNECT)
                                    || (granted && !prot.noPw);
                     end
                     // Unused op codes answer as refused, never hang
                     default: begin
                        rspValid <= 1'b1;
                        rspOk    <= 1'b0;
                        rspData  <= flash_lock_pkg::DATA_NONE;
                     end
                  endcase
               end
            end
            S_RD_WAIT: state <= S_RD_DATA;
            S_RD_DATA: begin
               rspValid <= 1'b1;
               rspOk    <= 1'b1;
               rspData  <= flashRdData;
               state    <= S_IDLE;
            end
            S_ERASE_APP, S_ERASE_ALL: begin
               if (sweepDone) begin
                  rspValid <= 1'b1;
                  rspOk    <= 1'b1;
                  rspData  <= flash_lock_pkg::DATA_NONE;
                  state    <= S_IDLE;
               end
            end
            default: state <= S_LOAD;
         endcase
      end
   end

   // ***************************************************************
   // Protection image
   // ***************************************************************
   // Restored one cycle after reset so a strap-like image is never lost
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         prot <= flash_lock_pkg::PROT_CLEAR;
      end else if (state == S_LOAD) begin
         prot <= protRestore;
      end else if (sweepDone) begin
         // Both erase kinds end unprotected
         prot.password <= flash_lock_pkg::PWD_DEFAULT;
         if (state == S_ERASE_ALL) begin
            prot <= flash_lock_pkg::PROT_CLEAR;
         end
      end else if (take && cmdReq.op == flash_lock_pkg::CMD_PROTECT &&
                   granted && !prot.noPw) begin
         // Passwordless mode keeps the password unset
         prot.password <= cmdReq.noPw ? flash_lock_pkg::PWD_DEFAULT
                                      : cmdReq.data;
         prot.appSize  <= cmdReq.size;
         prot.noPw     <= cmdReq.noPw;
      end
   end

   // ***************************************************************
   // Session grant
   // ***************************************************************
   // A fresh connection starts locked whenever a password is set
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         granted <= 1'b0;
      end else if (state == S_LOAD) begin
         granted <= (protRestore.password == flash_lock_pkg::PWD_DEFAULT);
      end else if (sweepDone) begin
         granted <= 1'b1;
      end else if (take && cmdReq.op == flash_lock_pkg::CMD_CONNECT) begin
         granted <= !pwSet;
      end
   end

   // ***************************************************************
   // Erase engine
   // ***************************************************************
   erase_sweeper u_sweeper (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .start   (sweepStart),
      .base    (flash_lock_pkg::FLASH_BASE),
      .len     (sweepLen),
      .done    (sweepDone),
      .wrEn    (flashWrEn),
      .wrAddr  (flashWrAddr),
      .wrData  (flashWrData)
   );

   // ***************************************************************
   // Checks
   // ***************************************************************
   property p_noPwReadRefused;
      @(posedge clk_sys) disable iff (!resetn)
      take && cmdReq.op == flash_lock_pkg::CMD_READ && prot.noPw
         |=> rspValid && !rspOk && !flashRdEn;
   endproperty
   a_noPwReadRefused: assert property (p_noPwReadRefused)
      else $error("read answered under passwordless lock");

   property p_connectLocks;
      @(posedge clk_sys) disable iff (!resetn)
      take && cmdReq.op == flash_lock_pkg::CMD_CONNECT && pwSet |=> !granted;
   endproperty
   a_connectLocks: assert property (p_connectLocks)
      else $error("new connection not locked");

   property p_lockedNoRead;
      @(posedge clk_sys) disable iff (!resetn)
      take && cmdReq.op == flash_lock_pkg::CMD_READ && !granted
         |=> !flashRdEn ##1 !flashRdEn;
   endproperty
   a_lockedNoRead: assert property (p_lockedNoRead)
      else $error("flash read while session locked");

   property p_goodPwErase;
      @(posedge clk_sys) disable iff (!resetn)
      take && cmdReq.op == flash_lock_pkg::CMD_PASSWORD &&
         pwSet && !prot.noPw && pwMatch
         |=> sweepStart && sweepLen == $past(prot.appSize);
   endproperty
   a_goodPwErase: assert property (p_goodPwErase)
      else $error("password erase length wrong");

   property p_badPw;
      @(posedge clk_sys) disable iff (!resetn)
      take && cmdReq.op == flash_lock_pkg::CMD_PASSWORD && pwSet && !pwMatch
         |=> !sweepStart && $stable(prot) && rspValid && !rspOk;
   endproperty
   a_badPw: assert property (p_badPw)
      else $error("wrong password changed state");

   property p_erasedValue;
      @(posedge clk_sys) disable iff (!resetn)
      flashWrEn |-> flashWrData == flash_lock_pkg::ERASED &&
                    (state == S_ERASE_APP || state == S_ERASE_ALL);
   endproperty
   a_erasedValue: assert property (p_erasedValue)
      else $error("flash write outside erase or not erased value");

   property p_pwCleared;
      @(posedge clk_sys) disable iff (!resetn)
      sweepDone && state == S_ERASE_APP
         |=> prot.password == flash_lock_pkg::PWD_DEFAULT && granted;
   endproperty
   a_pwCleared: assert property (p_pwCleared)
      else $error("password not cleared after erase");

   property p_fullErase;
      @(posedge clk_sys) disable iff (!resetn)
      take && cmdReq.op == flash_lock_pkg::CMD_FULL_ERASE
         |=> sweepStart && sweepLen == flash_lock_pkg::FLASH_BYTES
         ##1 flashWrAddr == flash_lock_pkg::FLASH_BASE && flashWrEn;
   endproperty
   a_fullErase: assert property (p_fullErase)
      else $error("full erase not started over whole array");

   property p_fullUnlock;
      @(posedge clk_sys) disable iff (!resetn)
      sweepDone && state == S_ERASE_ALL |=> !prot.noPw && granted;
   endproperty
   a_fullUnlock: assert property (p_fullUnlock)
      else $error("full erase left protection set");

endmodule // flash_readout_lock

/* File: testbench/flash_model.sv */
// Behavioural program flash seen by the readout lock.
// Assumes one read pulse per byte and one erase write per clock.
`timescale 1ns/1ps
module flash_model (
   // Clock
   input  wire logic                              clk_sys,
   // Read port
   input  wire logic                              flashRdEn,
   input  wire logic [flash_lock_pkg::ADDR_W-1:0] flashRdAddr,
   output      logic [flash_lock_pkg::DATA_W-1:0] flashRdData,
   // Erase write port
   input  wire logic                              flashWrEn,
   input  wire logic [flash_lock_pkg::ADDR_W-1:0] flashWrAddr,
   input  wire logic [flash_lock_pkg::DATA_W-1:0] flashWrData
);
   logic [7:0]  mem [65536];
   logic        rdEnDly = 1'b0;
   logic [7:0]  junk    = 8'h5A;
   logic [15:0] idx;

   // Known pattern, so an erase is visible
   initial begin
      for (int i = 0; i < 65536; i++) begin
         mem[i] = 8'(i) ^ 8'h3C;
      end
   end

   // Writes land at once; junk flips so stale data never passes
   always @(posedge clk_sys) begin
      rdEnDly <= flashRdEn;
      junk    <= ~junk;
      if (flashWrEn) begin
         mem[flashWrAddr[15:0]] <= flashWrData;
      end
   end

   // Data held for the pulse cycle and the one after it only
   assign idx         = flashRdAddr[15:0];
   assign flashRdData = (flashRdEn || rdEnDly) ? mem[idx] : junk;
endmodule // flash_model

/* File: testbench/flash_readout_lock_bench.sv */
// Self-checking bench for the flash readout lock.
// Assumes the design package and the flash model are compiled first.
`timescale 1ns/1ps
module flash_readout_lock_bench;
   typedef struct {
      flash_lock_pkg::cmd_op_t op;
      logic [31:0]             pwd;
      logic [16:0]             size;
      logic [19:0]             addr;
      logic                    expOk;
      logic [7:0]              expData;
   } row_t;

   logic                     clk_sys     = 1'b0;
   logic                     resetn      = 1'b0;
   logic                     cmdValid    = 1'b0;
   flash_lock_pkg::cmd_req_t cmdReq      = '0;
   flash_lock_pkg::prot_t    protRestore = flash_lock_pkg::PROT_CLEAR;
   flash_lock_pkg::prot_t    prot;
   logic                     cmdReady, rspValid, rspOk, granted;
   logic                     flashRdEn, flashWrEn, gotOk;
   logic [7:0]               rspData, flashRdData, flashWrData, gotData;
   logic [19:0]              flashRdAddr, flashWrAddr;
   int                       err_total = 0;
   int                       n_checks  = 0;
   int                       wrCount   = 0;
   int                       wrMark    = 0;
   row_t                     rows [7];

   always #4 clk_sys = ~clk_sys;

   flash_readout_lock i_dut (.clk_sys(clk_sys), .resetn(resetn),
      .cmdValid(cmdValid), .cmdReq(cmdReq), .cmdReady(cmdReady),
      .rspValid(rspValid), .rspOk(rspOk), .rspData(rspData),
      .flashRdEn(flashRdEn), .flashRdAddr(flashRdAddr),
      .flashRdData(flashRdData), .flashWrEn(flashWrEn),
      .flashWrAddr(flashWrAddr), .flashWrData(flashWrData),
      .protRestore(protRestore), .prot(prot), .granted(granted));

   flash_model i_flash (.clk_sys(clk_sys), .flashRdEn(flashRdEn),
      .flashRdAddr(flashRdAddr), .flashRdData(flashRdData),
      .flashWrEn(flashWrEn), .flashWrAddr(flashWrAddr),
      .flashWrData(flashWrData));

   // Erase strobes counted to prove the swept span
   always @(posedge clk_sys) begin
      if (resetn && flashWrEn) begin
         wrCount <= wrCount + 1;
      end
   end

   // ***************************************************************
   // Helpers
   // ***************************************************************
   function automatic logic [7:0] pat(input logic [19:0] a);
      return a[7:0] ^ 8'h3C;
   endfunction

   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic end_sim();
      $display("checks=%0d mismatches=%0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Five cycles low, then two edges for the image load
   task automatic do_reset();
      resetn = 1'b0;
      repeat (5) @(negedge clk_sys);
      resetn = 1'b1;
      repeat (2) @(negedge clk_sys);
   endtask

   // One command; held until taken, waits bounded for the answer
   task automatic send(input flash_lock_pkg::cmd_op_t op,
         input logic [31:0] pwd, input logic [16:0] size,
         input logic noPw, input logic [19:0] addr);
      int n;
      n = 0;
      while (cmdReady !== 1'b1 && n < 100) begin
         @(negedge clk_sys);
         n++;
      end
      if (cmdReady !== 1'b1) err_total++;
      cmdValid = 1'b1;
      cmdReq   = '{op: op, addr: addr, data: pwd, size: size, noPw: noPw};
      @(negedge clk_sys);
      cmdValid = 1'b0;
      n = 0;
      while (rspValid !== 1'b1 && n < 70000) begin
         @(negedge clk_sys);
         n++;
      end
      if (rspValid !== 1'b1) err_total++;
      gotOk   = rspOk;
      gotData = rspData;
      @(negedge clk_sys);
   endtask

   // Hang guard: whole run is one full erase, one 0x1800-byte erase, one 0x10-byte erase and short traffic
   initial begin
      repeat (90000) @(posedge clk_sys);
      err_total++;
      end_sim();
   end

   // ***************************************************************
   // Tests
   // ***************************************************************
   initial begin
      rows[0] = '{flash_lock_pkg::CMD_CONNECT, 32'h0, 17'h0, 20'h0,
                  1'b1, 8'h00};
      rows[1] = '{flash_lock_pkg::CMD_READ, 32'h0, 17'h0, 20'h90005,
                  1'b1, pat(20'h90005)};
      // Setup answers leave the last read byte standing on rspData
      rows[2] = '{flash_lock_pkg::CMD_PROTECT, 32'h12345678, 17'h01800,
                  20'h0, 1'b1, pat(20'h90005)};
      rows[3] = '{flash_lock_pkg::CMD_CONNECT, 32'h0, 17'h0, 20'h0,
                  1'b1, pat(20'h90005)};
      rows[4] = '{flash_lock_pkg::CMD_READ, 32'h0, 17'h0, 20'h90005,
                  1'b0, 8'h00};
      rows[5] = '{flash_lock_pkg::CMD_PASSWORD, 32'h12345679, 17'h0,
                  20'h0, 1'b0, 8'h00};
      rows[6] = '{flash_lock_pkg::CMD_READ, 32'h0, 17'h0, 20'h91800,
                  1'b0, 8'h00};
      do_reset();
      check(granted, 1'b1);
      foreach (rows[i]) begin
         send(rows[i].op, rows[i].pwd, rows[i].size, 1'b0, rows[i].addr);
         check(gotOk, rows[i].expOk);
         check(gotData, rows[i].expData);
         $display("row %0d done", i);
      end
      check(prot.password, 32'h12345678);
      check(wrCount, 0);

      // Correct password: erase of the protected span only
      wrMark = wrCount;
      send(flash_lock_pkg::CMD_PASSWORD, 32'h12345678, 17'h0, 1'b0,
           20'h0);
      check(gotOk, 1'b1);
      check(wrCount - wrMark, 32'h1800);
      check(i_flash.mem[16'h17FF], flash_lock_pkg::ERASED);
      check(i_flash.mem[16'h1800], pat(20'h91800));
      check(prot.password, flash_lock_pkg::PWD_DEFAULT);
      send(flash_lock_pkg::CMD_READ, 32'h0, 17'h0, 1'b0, 20'h90005);
      check({gotOk, gotData}, 9'h1FF);
      $display("password erase done");

      // Passwordless lock: no readback, no password, full erase only
      send(flash_lock_pkg::CMD_PROTECT, 32'hA5A5A5A5, 17'h00100, 1'b1,
           20'h0);
      check(prot.noPw, 1'b1);
      send(flash_lock_pkg::CMD_CONNECT, 32'h0, 17'h0, 1'b0, 20'h0);
      send(flash_lock_pkg::CMD_READ, 32'h0, 17'h0, 1'b0, 20'h9FFFF);
      check({gotOk, gotData}, 9'h000);
      send(flash_lock_pkg::CMD_PASSWORD, 32'hFFFFFFFF, 17'h0, 1'b0,
           20'h0);
      check(gotOk, 1'b0);
      wrMark = wrCount;
      send(flash_lock_pkg::CMD_FULL_ERASE, 32'h0, 17'h0, 1'b0,
           20'h0);
      check(gotOk, 1'b1);
      check(wrCount - wrMark, 32'h10000);
      check(prot, flash_lock_pkg::PROT_CLEAR);
      send(flash_lock_pkg::CMD_READ, 32'h0, 17'h0, 1'b0, 20'h9FFFF);
      check({gotOk, gotData}, 9'h1FF);
      $display("full erase done");

      // Restored image with a password: locked from the first cycle
      protRestore = '{password: 32'h0BADF00D, appSize: 17'h10, noPw: 1'b0};
      do_reset();
      check(granted, 1'b0);
      check(prot, protRestore);
      send(flash_lock_pkg::CMD_PROTECT, 32'h0, 17'h0, 1'b0, 20'h0);
      check({gotOk, prot.password}, {1'b0, 32'h0BADF00D});
      wrMark = wrCount;
      send(flash_lock_pkg::CMD_PASSWORD, 32'h0BADF00D, 17'h0, 1'b0,
           20'h0);
      check(wrCount - wrMark, 32'h10);
      check(gotOk, 1'b1);
      check(granted, 1'b1);
      $display("restore test done");
      end_sim();
   end
endmodule // flash_readout_lock_bench
